// ===== rtl/fpdma_ctrl.sv
// Packet DMA controller top: registers, engine, checksum, interrupts
// Function
// - Second set starts after first if nonzero
// - One engine, one direction at a time
// - Per-set address and count, shared direction
// - Inbound words summed across both sets
// - Checksum read clears it; a word in that cycle starts the new sum
// - Received packet moves leading block, interrupts
// - Inbound ends by count or end flag
// - Outbound packet end marked on last two words
// - Count exhaustion ends outbound packet
// - Outbound completion raises an interrupt
// - Both sets programmable before the start
// - First set carries up to 2048 words
// - Auto receive waits for lock and arm
// - Request write starts; receive code 10
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fpdma_ctrl (
	// Clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	// Register port
	input  wire logic [3:0]                    i_reg_addr,
	input  wire logic [31:0]                   i_reg_wdata,
	input  wire logic                          i_reg_wr,
	input  wire logic                          i_reg_rd,
	output logic      [31:0]                   o_reg_rdata,
	// Host memory word channel
	output logic      [fpdma_pkg::ADDR_W-1:0]  o_mem_addr,
	output logic                               o_mem_req,
	output logic                               o_mem_write,
	input  wire logic                          i_mem_ack,
	input  wire logic [31:0]                   i_mem_rdata,
	output logic      [31:0]                   o_mem_wdata,
	// MAC buffer word channel
	input  wire logic                          i_mac_rx_avail,
	input  wire logic                          i_mac_end,
	input  wire logic [31:0]                   i_mac_rdata,
	output logic      [31:0]                   o_mac_wdata,
	output logic                               o_mac_tag,
	output logic                               o_mac_dir_rx,
	output logic                               o_mac_queue,
	// Interrupt
	output logic                               o_irq
);
	import fpdma_pkg::*;

	fpdma_state_e              state;      // Engine state
	logic [1:0]                req;        // Channel service request
	logic                      queue;      // Priority queue bit
	logic                      armed;      // Receive armed
	logic                      dir_rx;     // Direction of running job
	logic                      lock;       // Direction lock
	logic [31:0]               csum;       // Inbound checksum
	logic [IRQ_N-1:0]          irq_st;     // Sticky events
	logic [IRQ_N-1:0]          irq_en;     // Event enables
	logic [ADDR_W-1:0]         addr1;      // First set address
	logic [ADDR_W-1:0]         addr2;      // Second set address
	logic [COUNT_W-1:0]        cnt1;       // First set count
	logic [COUNT_W-1:0]        cnt2;       // Second set count
	logic                      wr_req;     // Host writes control
	logic                      auto_rx;    // Automatic receive start
	logic                      busy;       // Engine moving words
	logic                      step;       // One word moved
	logic                      step1;      // Word from first set
	logic                      step2;      // Word from second set
	logic [COUNT_W:0]          left;       // Words left in the job
	logic                      last_word;  // Final word of the job
	logic                      rx_end_hit; // Inbound packet end seen
	logic [IRQ_N-1:0]          irq_set;    // Event pulses

	// Decode
	assign wr_req = i_reg_wr && i_reg_addr == CTRL_OFF;
	// Auto receive only with lock free and arm set
	assign auto_rx = state == FPDMA_IDLE && !lock && armed
		&& i_mac_rx_avail && !wr_req;
	assign busy = state == FPDMA_FIRST || state == FPDMA_SECOND;
	assign step = busy && i_mem_ack;
	assign step1 = step && state == FPDMA_FIRST;
	assign step2 = step && state == FPDMA_SECOND;
	// Second set counts only if the first will chain to it
	assign left = (state == FPDMA_FIRST) ? ({1'b0, cnt1} + {1'b0, cnt2})
		: {1'b0, cnt2};
	assign last_word = step && left == 13'h0001;
	assign rx_end_hit = step && dir_rx && i_mac_end;

	// Two register sets sharing one step source
	fpdma_set u_set1 (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_wr_addr  (i_reg_wr && i_reg_addr == ADDR1_OFF),
		.i_wr_count (i_reg_wr && i_reg_addr == COUNT1_OFF),
		.i_wdata    (i_reg_wdata),
		.i_step     (step1),
		.o_addr     (addr1),
		.o_count    (cnt1)
	);
	fpdma_set u_set2 (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_wr_addr  (i_reg_wr && i_reg_addr == ADDR2_OFF),
		.i_wr_count (i_reg_wr && i_reg_addr == COUNT2_OFF),
		.i_wdata    (i_reg_wdata),
		.i_step     (step2),
		.o_addr     (addr2),
		.o_count    (cnt2)
	);

	// Engine sequence; one job at a time in one direction
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= FPDMA_IDLE;
			dir_rx <= 1'b0;
		end else begin
			case (state)
				FPDMA_IDLE: begin
					if (wr_req && i_reg_wdata[1:0] != REQ_IDLE) begin
						// Host request starts at once
						dir_rx <= i_reg_wdata[1:0] == REQ_RX;
						state <= (cnt1 != '0) ? FPDMA_FIRST
							: FPDMA_DONE;
					end else if (auto_rx) begin
						dir_rx <= 1'b1;
						state <= (cnt1 != '0) ? FPDMA_FIRST
							: FPDMA_DONE;
					end
				end
				FPDMA_FIRST: begin
					if (rx_end_hit) begin
						state <= FPDMA_DONE;
					end else if (step && cnt1 == 12'h001) begin
						// Chain only when the second set has words
						state <= (cnt2 != '0) ? FPDMA_SECOND
							: FPDMA_DONE;
					end
				end
				FPDMA_SECOND: begin
					if (rx_end_hit || (step && cnt2 == 12'h001)) begin
						state <= FPDMA_DONE;
					end
				end
				FPDMA_DONE: begin
					state <= FPDMA_IDLE;
				end
				default: begin
					state <= FPDMA_IDLE;
				end
			endcase
		end
	end

	// Control register; hardware writes receive code on auto start
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			req <= CTRL_RST[1:0];
			queue <= CTRL_RST[CTRL_QUEUE];
			armed <= CTRL_RST[CTRL_ARM];
		end else if (wr_req) begin
			req <= i_reg_wdata[CTRL_REQ_LSB +: 2];
			queue <= i_reg_wdata[CTRL_QUEUE];
			armed <= i_reg_wdata[CTRL_ARM];
		end else if (auto_rx) begin
			req <= REQ_RX;
		end else if (state == FPDMA_DONE) begin
			req <= REQ_IDLE;
		end
	end

	// Lock set on grant, cleared only by a host write of zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lock <= 1'b0;
		end else if (auto_rx) begin
			lock <= 1'b1;
		end else if (i_reg_wr && i_reg_addr == LOCK_OFF) begin
			lock <= i_reg_wdata[0];
		end
	end

	// Checksum of inbound words; read clears, new word wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			csum <= ZERO32;
		end else if (step && dir_rx) begin
			csum <= ((i_reg_rd && i_reg_addr == CSUM_OFF) ? ZERO32 : csum)
				+ i_mac_rdata;
		end else if (i_reg_rd && i_reg_addr == CSUM_OFF) begin
			csum <= ZERO32;
		end
	end

	// Events at the end of each outbound job and of each inbound job that moves words
	always_comb begin
		irq_set = '0;
		if (state == FPDMA_DONE) begin
			irq_set[IRQ_TX] = !dir_rx;
		end
		if (dir_rx && busy) begin
			irq_set[IRQ_RXEND] = rx_end_hit;
			irq_set[IRQ_RXCNT] = last_word && !i_mac_end;
		end
	end

	// Sticky status; a new event wins over a clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_st <= '0;
		end else begin
			irq_st <= (irq_st & ~((i_reg_wr && i_reg_addr == IRQ_CL_OFF)
				? i_reg_wdata[IRQ_N-1:0] : '0)) | irq_set;
		end
	end

	// Enables
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_en <= '0;
		end else if (i_reg_wr && i_reg_addr == IRQ_EN_OFF) begin
			irq_en <= i_reg_wdata[IRQ_N-1:0];
		end
	end

	assign o_irq = |(irq_st & irq_en);

	// Read data one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= ZERO32;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR1_OFF:  o_reg_rdata <= {addr1, 2'b00};
				COUNT1_OFF: o_reg_rdata <= {20'h0_0000, cnt1};
				ADDR2_OFF:  o_reg_rdata <= {addr2, 2'b00};
				COUNT2_OFF: o_reg_rdata <= {20'h0_0000, cnt2};
				CTRL_OFF:   o_reg_rdata <= {28'h000_0000, armed, queue, req};
				LOCK_OFF:   o_reg_rdata <= {31'h0000_0000, lock};
				STATE_OFF:  o_reg_rdata <= {31'h0000_0000, busy};
				CSUM_OFF:   o_reg_rdata <= csum;
				IRQ_ST_OFF: o_reg_rdata <= {29'h0000_0000, irq_st};
				IRQ_EN_OFF: o_reg_rdata <= {29'h0000_0000, irq_en};
				default:    o_reg_rdata <= ZERO32;
			endcase
		end
	end

	// Data path; only one direction runs, no byte packing
	assign o_mem_req = busy;
	assign o_mem_write = busy && dir_rx;
	assign o_mem_addr = (state == FPDMA_SECOND) ? addr2 : addr1;
	assign o_mac_dir_rx = dir_rx;
	assign o_mac_queue = queue;
	// Tag on the final two words of an outbound job
	assign o_mac_tag = busy && !dir_rx && left <= 13'h0002
		&& left != 13'h0000;

	// Word registers between the two memories
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_wdata <= ZERO32;
			o_mac_wdata <= ZERO32;
		end else begin
			o_mem_wdata <= i_mac_rdata;
			o_mac_wdata <= i_mem_rdata;
		end
	end

	// All checks run on the one clock and rest during reset
	default clocking chk_cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// Job closes: one done cycle, then idle
	sequence close_s;
		state == FPDMA_DONE ##1 state == FPDMA_IDLE;
	endsequence

	// Tag must be up on the last outbound word
	tag_last_a: assert property (
		(last_word && !dir_rx) |-> o_mac_tag)
		else $error("tag missing on last word");
	// Chain goes to second set when words are there
	chain_a: assert property (
		(state == FPDMA_FIRST && step && cnt1 == 12'h001 && cnt2 != '0
		&& !rx_end_hit) |=> state == FPDMA_SECOND)
		else $error("second set not chained");
	// Auto receive grabs the lock
	auto_lock_a: assert property (
		auto_rx |=> lock && req == REQ_RX)
		else $error("auto receive lock missing");
	// No start while locked without host request
	wait_lock_a: assert property (
		(state == FPDMA_IDLE && (lock || !armed) && !wr_req)
		|=> state == FPDMA_IDLE)
		else $error("auto receive despite lock");
	// Checksum read clears
	csum_clr_a: assert property (
		(i_reg_rd && i_reg_addr == CSUM_OFF && !step) |=> csum == '0)
		else $error("checksum not cleared");
	// Outbound completion raises its status
	tx_irq_a: assert property (
		(state == FPDMA_DONE && !dir_rx) |=> irq_st[IRQ_TX])
		else $error("outbound status missing");
	// Packet end stops the inbound job
	rx_end_a: assert property (
		rx_end_hit |=> close_s)
		else $error("packet end ignored");
	// Each word lowers the first count by one
	count_a: assert property (
		(step1 && !i_reg_wr) |=> cnt1 == $past(cnt1) - 12'h001)
		else $error("count step wrong");
	// Lock stays unless the host writes it
	lock_hold_a: assert property (
		(lock && !(i_reg_wr && i_reg_addr == LOCK_OFF)) |=> lock)
		else $error("lock dropped by itself");
endmodule

// ===== rtl/fpdma_pkg.sv
// Package for the packet DMA controller: offsets, fields, widths, states
package fpdma_pkg;
	// Register word offsets on the plain register port
	localparam logic [3:0] ADDR1_OFF  = 4'h0; // First set host address
	localparam logic [3:0] COUNT1_OFF = 4'h1; // First set word count
	localparam logic [3:0] ADDR2_OFF  = 4'h2; // Second set host address
	localparam logic [3:0] COUNT2_OFF = 4'h3; // Second set word count
	localparam logic [3:0] CTRL_OFF   = 4'h4; // Transfer control
	localparam logic [3:0] LOCK_OFF   = 4'h5; // Direction lock
	localparam logic [3:0] STATE_OFF  = 4'h6; // Transfer state
	localparam logic [3:0] CSUM_OFF   = 4'h7; // Inbound checksum
	localparam logic [3:0] IRQ_ST_OFF = 4'h8; // Interrupt status
	localparam logic [3:0] IRQ_EN_OFF = 4'h9; // Interrupt enable
	localparam logic [3:0] IRQ_CL_OFF = 4'hA; // Interrupt clear
	// Widths
	localparam int ADDR_W  = 30;
	localparam int COUNT_W = 12;  // Up to 2048 words in one set
	localparam logic [11:0] MAX_COUNT = 12'h800; // 2048 words
	// Control fields
	localparam int CTRL_REQ_LSB = 0; // Channel service request, 2 bits
	localparam int CTRL_QUEUE   = 2; // Priority queue bit to the MAC
	localparam int CTRL_ARM     = 3; // Receive armed
	localparam logic [1:0] REQ_IDLE = 2'h0;
	localparam logic [1:0] REQ_TX   = 2'h1;
	localparam logic [1:0] REQ_RX   = 2'h2;
	// Interrupt status bits
	localparam int IRQ_N     = 3;
	localparam int IRQ_TX    = 0; // Outbound done
	localparam int IRQ_RXCNT = 1; // Inbound ended by word count
	localparam int IRQ_RXEND = 2; // Inbound ended by packet end
	// Reset values
	localparam logic [3:0]  CTRL_RST = 4'h0;
	localparam logic [31:0] ZERO32   = 32'h0000_0000;
	// Engine states, Gray along idle-first-second-done
	typedef enum logic [1:0] {
		FPDMA_IDLE   = 2'b00,
		FPDMA_FIRST  = 2'b01,
		FPDMA_SECOND = 2'b11,
		FPDMA_DONE   = 2'b10
	} fpdma_state_e;
endpackage

// ===== rtl/fpdma_set.sv
// One register set: host address and word count with step logic
`timescale 1ns/1ps
module fpdma_set (
	// Clock and reset
	input  wire logic                            i_clk,
	input  wire logic                            i_rst,
	// Host programming
	input  wire logic                            i_wr_addr,
	input  wire logic                            i_wr_count,
	input  wire logic [31:0]                     i_wdata,
	// Engine step
	input  wire logic                            i_step,
	// State
	output logic      [fpdma_pkg::ADDR_W-1:0]    o_addr,
	output logic      [fpdma_pkg::COUNT_W-1:0]   o_count
);
	import fpdma_pkg::*;

	// Address advances one word (four bytes) per step
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_addr <= '0;
		end else if (i_wr_addr) begin
			o_addr <= i_wdata[31:2];
		end else if (i_step) begin
			o_addr <= o_addr + 30'h1;
		end
	end

	// Count falls one per word, limited to the largest set size
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_count <= '0;
		end else if (i_wr_count) begin
			// Larger values clip to 2048 words
			o_count <= (i_wdata[31:0] > 32'h0000_0800) ? MAX_COUNT
				: i_wdata[COUNT_W-1:0];
		end else if (i_step && o_count != '0) begin
			o_count <= o_count - 12'h001;
		end
	end
endmodule

// ===== verif/fpdma_model.sv
// Far-side model: host memory and MAC buffer word channels
`timescale 1ns/1ps
module fpdma_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Engine side
	input  wire logic [29:0] i_addr,
	input  wire logic        i_req,
	input  wire logic        i_write,
	input  wire logic        i_tag,
	// Test control
	input  wire logic        i_clr,
	input  wire logic        i_slow,
	input  wire logic [11:0] i_end_at,
	// Answers
	output logic             o_ack,
	output logic [31:0]      o_mem_rdata,
	output logic [31:0]      o_mac_rdata,
	output logic             o_mac_end
);
	logic [11:0] acks;            // Words moved in this job
	logic [2:0]  dly;             // Stall countdown
	logic [29:0] addr_log [0:63]; // Address of each word
	logic [63:0] tag_log;         // Marker seen on each word
	logic [31:0] word;            // One bit per word
	// Disjoint bits keep any crude sum equal to an OR
	assign word = 32'h1 << acks[4:0];
	// Released lines show the inverse, not the last value
	assign o_mem_rdata = o_ack ? word : ~word;
	assign o_mac_rdata = o_ack ? word : ~word;
	// End flag only on the chosen inbound word
	assign o_mac_end = o_ack && i_write && (acks + 12'h1 == i_end_at);
	// One word per answer, never on two cycles in a row
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			acks <= 12'h0;
			dly <= 3'h0;
			tag_log <= 64'h0;
		end else if (i_clr) begin
			acks <= 12'h0;
			tag_log <= 64'h0;
		end else begin
			o_ack <= i_req && !o_ack && (dly == 3'h0);
			if (o_ack) begin
				addr_log[acks[5:0]] <= i_addr;
				tag_log[acks[5:0]] <= i_tag;
				acks <= acks + 12'h1;
				dly <= i_slow ? 3'h5 : 3'h0;
			end else if (dly != 3'h0) begin
				dly <= dly - 3'h1;
			end
		end
	end
endmodule

// ===== verif/fpdma_ctrl_tb_top.sv
// Testbench for the packet DMA controller
`timescale 1ns/1ps
module fpdma_ctrl_tb_top;
	import fpdma_pkg::*;
	logic        clk, rst, wr, rd, clr, slow, rxav;
	logic [3:0]  ra;
	logic [31:0] wd, rdata, mrd, mwd, macrd, macwd;
	logic [29:0] maddr;
	logic        req, mw, ack, mend, tag, dirrx, queue, irq;
	logic [11:0] end_at;
	int          miscompares, cmp_count;
	fpdma_ctrl u_fpdma_ctrl (.i_clk(clk), .i_rst(rst), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_mem_addr(maddr), .o_mem_req(req), .o_mem_write(mw),
		.i_mem_ack(ack), .i_mem_rdata(mrd), .o_mem_wdata(mwd),
		.i_mac_rx_avail(rxav), .i_mac_end(mend), .i_mac_rdata(macrd),
		.o_mac_wdata(macwd), .o_mac_tag(tag), .o_mac_dir_rx(dirrx),
		.o_mac_queue(queue), .o_irq(irq));
	fpdma_model u_fpdma_model (.i_clk(clk), .i_rst(rst), .i_addr(maddr),
		.i_req(req), .i_write(mw), .i_tag(tag), .i_clr(clr),
		.i_slow(slow), .i_end_at(end_at), .o_ack(ack),
		.o_mem_rdata(mrd), .o_mac_rdata(macrd), .o_mac_end(mend));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle register write; settle before return
	task automatic wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// Read; data stands from the following cycle until the next read
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		ra <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Program both sets and clear the model log
	task automatic setup(input logic [31:0] a1, c1, a2, c2);
		wrr(ADDR1_OFF, a1);
		wrr(COUNT1_OFF, c1);
		wrr(ADDR2_OFF, a2);
		wrr(COUNT2_OFF, c2);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	// Bounded wait for the interrupt
	task automatic wait_irq();
		for (int n = 0; n < 10000 && irq !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(32'(irq), 32'h1);
	endtask
	// Reset values, unmapped place, idle request code
	task automatic s_regs();
		wrr(4'hB, 32'hFFFF_FFFF);
		for (int a = 0; a < 12; a++)
			rchk(4'(a), 32'h0);
		wrr(COUNT1_OFF, 32'h3);
		wrr(CTRL_OFF, 32'h0);
		rchk(STATE_OFF, 32'h0);
	endtask
	// Outbound through both sets
	task automatic s_tx_two();
		wrr(LOCK_OFF, 32'h1);
		wrr(IRQ_EN_OFF, 32'h7);
		setup(32'h100, 32'h3, 32'h800, 32'h2);
		wrr(CTRL_OFF, 32'h5);
		wait_irq();
		chk(32'(u_fpdma_model.acks), 32'h5);
		for (int k = 0; k < 3; k++)
			chk(32'(u_fpdma_model.addr_log[k]), 32'h40 + k);
		for (int k = 0; k < 2; k++)
			chk(32'(u_fpdma_model.addr_log[3+k]), 32'h200 + k);
		chk(32'(u_fpdma_model.tag_log[4:0]), 32'h18);
		chk({30'h0, dirrx, queue}, 32'h1);
		rchk(IRQ_ST_OFF, 32'h1);
		rchk(CTRL_OFF, 32'h4);
		rchk(ADDR1_OFF, 32'h10C);
		rchk(COUNT1_OFF, 32'h0);
		rchk(LOCK_OFF, 32'h1);
		rchk(CSUM_OFF, 32'h0);
		wrr(IRQ_CL_OFF, 32'h7);
		chk(32'(irq), 32'h0);
	endtask
	// Empty second set, slow far side, masked interrupt
	task automatic s_tx_masked();
		wrr(IRQ_EN_OFF, 32'h0);
		setup(32'h200, 32'h2, 32'h900, 32'h0);
		slow <= 1'b1;
		wrr(CTRL_OFF, 32'h1);
		for (int n = 0; n < 200 && u_fpdma_model.acks != 12'h2; n++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		chk(32'(u_fpdma_model.acks), 32'h2);
		chk(32'(u_fpdma_model.tag_log[1:0]), 32'h3);
		chk(32'(irq), 32'h0);
		rchk(IRQ_ST_OFF, 32'h1);
		wrr(IRQ_EN_OFF, 32'h7);
		chk(32'(irq), 32'h1);
		wrr(IRQ_CL_OFF, 32'h1);
		chk(32'(irq), 32'h0);
		slow <= 1'b0;
	endtask
	// Largest first set, clipped count
	task automatic s_max();
		setup(32'h0, 32'h801, 32'h0, 32'h0);
		rchk(COUNT1_OFF, 32'h800);
		wrr(CTRL_OFF, 32'h1);
		wait_irq();
		chk(32'(u_fpdma_model.acks), 32'h800);
		chk(32'(u_fpdma_model.tag_log[63:61]), 32'h6);
		wrr(IRQ_CL_OFF, 32'h7);
	endtask
	// Auto receive held off by the lock, ended by count
	task automatic s_rx_wait();
		setup(32'h400, 32'h4, 32'h0, 32'h0);
		end_at <= 12'h0;
		slow <= 1'b1;
		wrr(LOCK_OFF, 32'h1);
		wrr(CTRL_OFF, 32'h8);
		rxav <= 1'b1;
		repeat (20) @(posedge clk);
		chk(32'(u_fpdma_model.acks), 32'h0);
		wrr(LOCK_OFF, 32'h0);
		rchk(CTRL_OFF, 32'hA);
		rchk(LOCK_OFF, 32'h1);
		chk({30'h0, mw, dirrx}, 32'h3);
		wait_irq();
		rxav <= 1'b0;
		slow <= 1'b0;
		rchk(IRQ_ST_OFF, 32'h2);
		rchk(CSUM_OFF, 32'hF);
		rchk(CSUM_OFF, 32'h0);
		wrr(IRQ_CL_OFF, 32'h7);
	endtask
	// Auto receive across sets, ended by the packet end flag
	task automatic s_rx_end();
		setup(32'h500, 32'h2, 32'hA00, 32'h4);
		end_at <= 12'h3;
		wrr(LOCK_OFF, 32'h0);
		rxav <= 1'b1;
		wait_irq();
		rxav <= 1'b0;
		chk(32'(u_fpdma_model.acks), 32'h3);
		chk(32'(u_fpdma_model.addr_log[2]), 32'h280);
		rchk(IRQ_ST_OFF, 32'h4);
		rchk(CSUM_OFF, 32'h7);
		chk(mwd, 32'hFFFF_FFF7);
		chk(macwd, 32'hFFFF_FFF7);
	endtask
	// Host-started receive with request code 10, ended by count
	task automatic s_rx_host();
		wrr(IRQ_CL_OFF, 32'h7);
		setup(32'h600, 32'h2, 32'h0, 32'h0);
		end_at <= 12'h0;
		wrr(CTRL_OFF, 32'h2);
		wait_irq();
		chk({30'h0, mw, dirrx}, 32'h1);
		chk(32'(u_fpdma_model.acks), 32'h2);
		rchk(IRQ_ST_OFF, 32'h2);
		rchk(CTRL_OFF, 32'h0);
		rchk(ADDR1_OFF, 32'h608);
		rchk(CSUM_OFF, 32'h3);
		chk(mwd, 32'hFFFF_FFFB);
	endtask
	// Verdict and end of run
	task automatic results();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst, wr, rd, clr, slow, rxav} = 6'b100000;
		{ra, wd, end_at} = 48'h0;
		miscompares = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		s_regs();
		s_tx_two();
		s_tx_masked();
		s_max();
		s_rx_wait();
		s_rx_end();
		s_rx_host();
		results();
	end
	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule
